// File: rdsm_map.svh
// Offsets, field positions, reset values and timing counts of the reset and supply manager.
// Assumes inclusion by the package through a bare-name include; the core uses its macros from there.
`ifndef RDSM_MAP_SVH
`define RDSM_MAP_SVH

// AXI4-Lite byte addresses of the block's registers.
`define RDSM_PWR_CTRL_OFS 12'h000
`define RDSM_STATUS_OFS 12'h004
`define RDSM_SWRST_OFS 12'h008

// Field positions inside power_control_reg.
`define RDSM_REG_ON_BIT 0
`define RDSM_DETEN_BIT 1
`define RDSM_VSEL_LO 2
`define RDSM_VSEL_HI 3
`define RDSM_PLUG_IE_BIT 4
`define RDSM_PLUG_BIT 5
`define RDSM_ITMF_BIT 6
`define RDSM_ITPF_BIT 7
`define RDSM_PWR_CTRL_RST 8'h00

// Sequencer timing in cycles and the width of its counter in bits.
`define RDSM_SA_DELAY 512
`define RDSM_USB_DELAY 256
`define RDSM_FETCH_CYCLES 2
`define RDSM_CNT_W 10

// Regulator voltage codes.
`define RDSM_VSEL_3V5 2'h0
`define RDSM_VSEL_3V4 2'h1
`define RDSM_VSEL_3V3 2'h2
`define RDSM_VSEL_2V8 2'h3

// PLL frequency and core clock caps in MHz.
`define RDSM_PLL_MHZ 8'h30
`define RDSM_USB_CORE_MHZ 8'h08
`define RDSM_SA_CORE_MHZ 8'h06

`endif

// File: rdsm_pkg.sv
// Types shared by the reset delay and supply mode manager.
// Assumes rdsm_map.svh is on the include path.
package rdsm_pkg;
  `include "rdsm_map.svh"

  typedef enum logic [2:0] {
    RDSM_ST_ACTIVE = 3'b000,
    RDSM_ST_WAIT_LOCK = 3'b001,
    RDSM_ST_DELAY = 3'b010,
    RDSM_ST_FETCH = 3'b011,
    RDSM_ST_RUN = 3'b100
  } rdsm_state_e;

  typedef struct packed {
    logic awvalid;
    logic [11:0] awaddr;
    logic wvalid;
    logic [31:0] wdata;
    logic [3:0] wstrb;
    logic bready;
    logic arvalid;
    logic [11:0] araddr;
    logic rready;
  } rdsm_axi_req_s;

  typedef struct packed {
    logic awready;
    logic wready;
    logic bvalid;
    logic [1:0] bresp;
    logic arready;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
  } rdsm_axi_rsp_s;

  typedef struct packed {
    logic pll_enable;
    logic usb_enable;
    logic [7:0] core_max_mhz;
    logic clk_from_xtal_div;
  } rdsm_clk_ctrl_s;
endpackage

// File: rdsm_sync.sv
// Two-flop synchroniser for a vector of asynchronous levels.
// Assumes the inputs come from analog detectors or pins outside the clock domain.
`timescale 1ns/10ps
module rdsm_sync #(
  parameter int W = 4
) (
  input wire logic clk_sys_i,
  input wire logic sys_rst_i,
  input wire logic [W-1:0] async_i,
  output logic [W-1:0] sync_o
);
  logic [W-1:0] meta_q;
  logic [W-1:0] sync_q;

  always_ff @(posedge clk_sys_i) begin
    if (sys_rst_i) begin
      meta_q <= '0;
      sync_q <= '0;
    end else begin
      meta_q <= async_i;
      sync_q <= meta_q;
    end
  end

  assign sync_o = sync_q;
endmodule

// File: rdsm_core.sv
// Reset delay sequencer and supply mode manager with an AXI4-Lite register slave.
// Assumes the analog detectors give raw levels and the pin pad resolves the enables.
// How it works
// RQ1 - Stand-alone: hold reset 512 cycles after active phase
// RQ2 - USB mode: 256 cycles counted from PLL lock
// RQ3 - Vector fetch lasts exactly two cycles
// RQ4 - Low-voltage reset uses rising and falling thresholds
// RQ5 - Drive reset pin low during low-voltage reset
// RQ6 - Single supply: software leaves plug interrupt disabled
// RQ7 - USB modes: PLL 48 MHz, USB on, 8 MHz
// RQ8 - Stand-alone: PLL off, USB off, 6 MHz, switch floating
// RQ9 - USB mode: drive supply switch low, even in reset
// RQ10 - Dual supply: option byte and software enable interrupt
// RQ11 - Plug interrupt at rising threshold when enabled
// RQ12 - Software resets after plug to enter USB mode
// RQ13 - Software reset floats every I/O port
// RQ14 - USB-mode unplug at falling threshold raises interrupt
// RQ15 - Software resets before supply drops below PLL minimum
// RQ16 - After unplug reset: switch floats, PLL stops, crystal divides
// RQ17 - Software clears regulator_enable when supply is external
// RQ18 - Regulator level selectable among four voltages
// RQ19 - Voltage code 00 3.5V, 01 3.4V, 10 3.3V, 11 2.8V
// RQ20 - Interrupt on plug_detect rising edge when enabled
// RQ21 - Delay mode sampled at phase end, restarts on reset
`timescale 1ns/10ps
module rdsm_core (
  input wire logic clk_sys_i,
  input wire logic sys_rst_i,
  input wire rdsm_pkg::rdsm_axi_req_s axi_req_i,
  output rdsm_pkg::rdsm_axi_rsp_s axi_rsp_o,
  input wire logic ext_reset_n_i,
  input wire logic watchdog_reset_i,
  input wire logic vdd_above_rising_i,
  input wire logic vdd_above_falling_i,
  input wire logic usb_above_rising_i,
  input wire logic usb_above_falling_i,
  input wire logic pll_lock_i,
  output logic reset_pin_o,
  output logic reset_pin_oe_o,
  output logic core_reset_o,
  output logic vector_fetch_o,
  output logic io_float_o,
  output logic usb_supply_switch_out_o,
  output logic usb_supply_switch_out_oe_o,
  output rdsm_pkg::rdsm_clk_ctrl_s clk_ctrl_o,
  output logic regulator_enable_o,
  output logic [1:0] regulator_voltage_sel_o,
  output logic [1:0] regulator_level_code_o,
  output logic detector_power_down_o,
  output logic plug_irq_o
);
  import rdsm_pkg::*;

  // Synchronised analog and pin levels.
  logic [5:0] raw_in;
  logic [5:0] syn;
  assign raw_in = {~ext_reset_n_i, vdd_above_rising_i, vdd_above_falling_i,
                   usb_above_rising_i, usb_above_falling_i, pll_lock_i};

  rdsm_sync #(.W(6)) u_sync (
    .clk_sys_i(clk_sys_i),
    .sys_rst_i(sys_rst_i),
    .async_i(raw_in),
    .sync_o(syn)
  );

  wire ext_rst = syn[5];
  wire vdd_rise_ok = syn[4];
  wire vdd_fall_ok = syn[3];
  wire usb_rise_raw = syn[2];
  wire usb_fall_raw = syn[1];
  wire pll_lock = syn[0];

  // Registers.
  logic reg_on_q, reg_on_d;
  logic deten_q, deten_d;
  logic [1:0] vsel_q, vsel_d;
  logic plug_ie_q, plug_ie_d;
  logic plug_q, plug_d;
  logic plug_irq_q, plug_irq_d;
  logic vdd_good_q, vdd_good_d;
  logic usb_mode_q, usb_mode_d;
  logic sw_rst_q, sw_rst_d;
  logic sw_rst_seen_q, sw_rst_seen_d;
  logic cnt_usb_q, cnt_usb_d;
  logic [`RDSM_CNT_W-1:0] cnt_q, cnt_d;
  rdsm_state_e state_q, state_d;

  // Detector power-down forces the threshold flags high.
  wire itpf = usb_rise_raw | deten_q;
  wire itmf = usb_fall_raw | deten_q;

  // Low-voltage detector with hysteresis.
  // Good once above the rising threshold, bad once below the falling one.
  always_comb begin
    vdd_good_d = vdd_good_q;
    if (vdd_rise_ok) begin
      vdd_good_d = 1'b1; // see RQ4
    end else if (!vdd_fall_ok) begin
      vdd_good_d = 1'b0; // see RQ4
    end
  end

  // Plug state: set above rising threshold, cleared below falling threshold.
  always_comb begin
    plug_d = plug_q;
    if (itpf) begin
      plug_d = 1'b1; // see RQ11
    end else if (!itmf) begin
      plug_d = 1'b0; // see RQ14
    end
  end

  wire low_vdd_reset = !vdd_good_q;
  wire any_reset = low_vdd_reset | ext_rst | watchdog_reset_i | sw_rst_q;
  wire plug_rise = plug_d & !plug_q;

  // AXI4-Lite slave: one write and one read at a time.
  logic aw_hold_q, aw_hold_d;
  logic w_hold_q, w_hold_d;
  logic [11:0] awaddr_q, awaddr_d;
  logic [31:0] wdata_q, wdata_d;
  logic [3:0] wstrb_q, wstrb_d;
  logic bvalid_q, bvalid_d;
  logic [1:0] bresp_q, bresp_d;
  logic rvalid_q, rvalid_d;
  logic [31:0] rdata_q, rdata_d;
  logic [1:0] rresp_q, rresp_d;

  wire awready = !aw_hold_q && !bvalid_q;
  wire wready = !w_hold_q && !bvalid_q;
  wire aw_fire = axi_req_i.awvalid && awready;
  wire w_fire = axi_req_i.wvalid && wready;
  wire aw_have = aw_hold_q || aw_fire;
  wire w_have = w_hold_q || w_fire;
  wire wr_go = aw_have && w_have;
  wire [11:0] wr_addr = aw_hold_q ? awaddr_q : axi_req_i.awaddr;
  wire [31:0] wr_data = w_hold_q ? wdata_q : axi_req_i.wdata;
  wire [3:0] wr_strb = w_hold_q ? wstrb_q : axi_req_i.wstrb;
  wire arready = !rvalid_q;
  wire ar_fire = axi_req_i.arvalid && arready;

  function automatic logic addr_mapped(input logic [11:0] a);
    addr_mapped = (a == `RDSM_PWR_CTRL_OFS) || (a == `RDSM_STATUS_OFS) ||
                  (a == `RDSM_SWRST_OFS);
  endfunction

  wire wr_ctrl = wr_go && (wr_addr == `RDSM_PWR_CTRL_OFS) && wr_strb[0];
  wire wr_swrst = wr_go && (wr_addr == `RDSM_SWRST_OFS) && wr_strb[0] && wr_data[0];

  wire [7:0] ctrl_view = {itpf, itmf, plug_q, plug_ie_q, vsel_q, deten_q, reg_on_q};
  wire [31:0] status_view = {24'h0000_00, 3'h0, usb_mode_q, plug_irq_q,
                             sw_rst_seen_q, low_vdd_reset, state_q == RDSM_ST_RUN};

  always_comb begin
    aw_hold_d = aw_hold_q;
    w_hold_d = w_hold_q;
    awaddr_d = awaddr_q;
    wdata_d = wdata_q;
    wstrb_d = wstrb_q;
    bvalid_d = bvalid_q;
    bresp_d = bresp_q;
    rvalid_d = rvalid_q;
    rdata_d = rdata_q;
    rresp_d = rresp_q;
    if (aw_fire) begin
      aw_hold_d = 1'b1;
      awaddr_d = axi_req_i.awaddr;
    end
    if (w_fire) begin
      w_hold_d = 1'b1;
      wdata_d = axi_req_i.wdata;
      wstrb_d = axi_req_i.wstrb;
    end
    if (wr_go) begin
      aw_hold_d = 1'b0;
      w_hold_d = 1'b0;
      bvalid_d = 1'b1;
      bresp_d = addr_mapped(wr_addr) ? 2'h0 : 2'h2;
    end else if (bvalid_q && axi_req_i.bready) begin
      bvalid_d = 1'b0;
    end
    if (ar_fire) begin
      rvalid_d = 1'b1;
      rresp_d = addr_mapped(axi_req_i.araddr) ? 2'h0 : 2'h2;
      if (axi_req_i.araddr == `RDSM_PWR_CTRL_OFS) begin
        rdata_d = {24'h0000_00, ctrl_view};
      end else if (axi_req_i.araddr == `RDSM_STATUS_OFS) begin
        rdata_d = status_view;
      end else begin
        rdata_d = 32'h0000_0000;
      end
    end else if (rvalid_q && axi_req_i.rready) begin
      rvalid_d = 1'b0;
    end
  end

  // Software-owned control bits and the plug interrupt flag.
  always_comb begin
    reg_on_d = reg_on_q;
    deten_d = deten_q;
    vsel_d = vsel_q;
    plug_ie_d = plug_ie_q;
    plug_irq_d = plug_irq_q;
    if (wr_ctrl) begin
      reg_on_d = wr_data[`RDSM_REG_ON_BIT];
      deten_d = wr_data[`RDSM_DETEN_BIT];
      vsel_d = wr_data[`RDSM_VSEL_HI:`RDSM_VSEL_LO]; // see RQ18
      plug_ie_d = wr_data[`RDSM_PLUG_IE_BIT];
      // Writing one to the plug bit clears the pending request.
      if (wr_data[`RDSM_PLUG_BIT]) begin
        plug_irq_d = 1'b0;
      end
    end
    // A new edge wins over a simultaneous clear; an unplug only counts in USB mode.
    if ((plug_rise || (usb_mode_q && plug_q && !plug_d)) && plug_ie_q) begin
      plug_irq_d = 1'b1; // see RQ20 RQ14
    end
    if (!plug_ie_q) begin
      plug_irq_d = 1'b0; // see RQ11
    end
  end

  // Software reset request and the supply mode it latches.
  always_comb begin
    sw_rst_d = wr_swrst;
    sw_rst_seen_d = sw_rst_seen_q | wr_swrst;
    usb_mode_d = usb_mode_q;
    // The supply mode changes only while a reset is active.
    if (any_reset) begin
      usb_mode_d = plug_q; // see RQ9
    end
  end

  // Reset sequencer.
  always_comb begin
    state_d = state_q;
    cnt_d = cnt_q;
    cnt_usb_d = cnt_usb_q;
    if (any_reset) begin
      state_d = RDSM_ST_ACTIVE; // see RQ21
      cnt_d = '0;
    end else begin
      unique case (state_q)
        RDSM_ST_ACTIVE: begin
          cnt_usb_d = usb_mode_q; // see RQ21
          cnt_d = '0;
          state_d = usb_mode_q ? RDSM_ST_WAIT_LOCK : RDSM_ST_DELAY;
        end
        RDSM_ST_WAIT_LOCK: begin
          if (pll_lock) begin
            state_d = RDSM_ST_DELAY; // see RQ2
          end
        end
        RDSM_ST_DELAY: begin
          cnt_d = cnt_q + `RDSM_CNT_W'(1);
          if (cnt_usb_q ? (cnt_q == `RDSM_CNT_W'(`RDSM_USB_DELAY - 1)) // see RQ2
                        : (cnt_q == `RDSM_CNT_W'(`RDSM_SA_DELAY - 1))) begin // see RQ1
            cnt_d = '0;
            state_d = RDSM_ST_FETCH;
          end
        end
        RDSM_ST_FETCH: begin
          cnt_d = cnt_q + `RDSM_CNT_W'(1);
          if (cnt_q == `RDSM_CNT_W'(`RDSM_FETCH_CYCLES - 1)) begin
            state_d = RDSM_ST_RUN; // see RQ3
          end
        end
        RDSM_ST_RUN: begin
          state_d = RDSM_ST_RUN;
        end
        default: begin
          state_d = RDSM_ST_ACTIVE;
        end
      endcase
    end
  end

  always_ff @(posedge clk_sys_i) begin
    if (sys_rst_i) begin
      reg_on_q <= 1'b0;
      deten_q <= 1'b0;
      vsel_q <= `RDSM_VSEL_3V5;
      plug_ie_q <= 1'b0; // see RQ6
      plug_q <= 1'b0;
      plug_irq_q <= 1'b0;
      vdd_good_q <= 1'b0;
      usb_mode_q <= 1'b0;
      sw_rst_q <= 1'b0;
      sw_rst_seen_q <= 1'b0;
      cnt_usb_q <= 1'b0;
      cnt_q <= '0;
      state_q <= RDSM_ST_ACTIVE;
    end else begin
      reg_on_q <= reg_on_d;
      deten_q <= deten_d;
      vsel_q <= vsel_d;
      plug_ie_q <= plug_ie_d;
      plug_q <= plug_d;
      plug_irq_q <= plug_irq_d;
      vdd_good_q <= vdd_good_d;
      usb_mode_q <= usb_mode_d;
      sw_rst_q <= sw_rst_d;
      sw_rst_seen_q <= sw_rst_seen_d;
      cnt_usb_q <= cnt_usb_d;
      cnt_q <= cnt_d;
      state_q <= state_d;
    end
  end

  always_ff @(posedge clk_sys_i) begin
    if (sys_rst_i) begin
      aw_hold_q <= 1'b0;
      w_hold_q <= 1'b0;
      awaddr_q <= 12'h000;
      wdata_q <= 32'h0000_0000;
      wstrb_q <= 4'h0;
      bvalid_q <= 1'b0;
      bresp_q <= 2'h0;
      rvalid_q <= 1'b0;
      rdata_q <= 32'h0000_0000;
      rresp_q <= 2'h0;
    end else begin
      aw_hold_q <= aw_hold_d;
      w_hold_q <= w_hold_d;
      awaddr_q <= awaddr_d;
      wdata_q <= wdata_d;
      wstrb_q <= wstrb_d;
      bvalid_q <= bvalid_d;
      bresp_q <= bresp_d;
      rvalid_q <= rvalid_d;
      rdata_q <= rdata_d;
      rresp_q <= rresp_d;
    end
  end

  // Bus answers.
  assign axi_rsp_o.awready = awready;
  assign axi_rsp_o.wready = wready;
  assign axi_rsp_o.bvalid = bvalid_q;
  assign axi_rsp_o.bresp = bresp_q;
  assign axi_rsp_o.arready = arready;
  assign axi_rsp_o.rvalid = rvalid_q;
  assign axi_rsp_o.rdata = rdata_q;
  assign axi_rsp_o.rresp = rresp_q;

  // Reset pin is open drain, pulled low through the whole sequence.
  wire in_seq = (state_q != RDSM_ST_RUN);
  assign reset_pin_o = 1'b0;
  assign reset_pin_oe_o = in_seq | low_vdd_reset; // see RQ5
  assign core_reset_o = in_seq;
  assign vector_fetch_o = (state_q == RDSM_ST_FETCH); // see RQ3
  assign io_float_o = in_seq; // see RQ13

  // Supply switch: low in USB mode, floating otherwise.
  assign usb_supply_switch_out_o = 1'b0;
  assign usb_supply_switch_out_oe_o = usb_mode_q; // see RQ9
  assign clk_ctrl_o.pll_enable = usb_mode_q; // see RQ7
  assign clk_ctrl_o.usb_enable = usb_mode_q; // see RQ8
  assign clk_ctrl_o.core_max_mhz = usb_mode_q ? `RDSM_USB_CORE_MHZ : `RDSM_SA_CORE_MHZ;
  assign clk_ctrl_o.clk_from_xtal_div = !usb_mode_q; // see RQ16

  assign regulator_enable_o = reg_on_q;
  assign regulator_voltage_sel_o = vsel_q; // see RQ19
  assign regulator_level_code_o = vsel_q;
  assign detector_power_down_o = deten_q;
  assign plug_irq_o = plug_irq_q; // see RQ11
endmodule

// File: rdsm_core_sva.sv
// Concurrent checks on the reset and supply manager ports.
// Assumes binding to rdsm_core; all inputs are its ports.
`timescale 1ns/10ps
module rdsm_core_sva (
  input wire logic clk_sys_i,
  input wire logic sys_rst_i,
  input wire logic vdd_above_falling_i,
  input wire logic pll_lock_i,
  input wire logic reset_pin_o,
  input wire logic reset_pin_oe_o,
  input wire logic core_reset_o,
  input wire logic vector_fetch_o,
  input wire logic io_float_o,
  input wire logic usb_supply_switch_out_o,
  input wire logic usb_supply_switch_out_oe_o,
  input wire rdsm_pkg::rdsm_clk_ctrl_s clk_ctrl_o,
  input wire logic [1:0] regulator_voltage_sel_o,
  input wire logic [1:0] regulator_level_code_o
);
  import rdsm_pkg::*;
  logic [15:0] hold_q;
  logic [15:0] lock_q;
  // Cycles held in reset before the fetch, and cycles of steady lock.
  always_ff @(posedge clk_sys_i) begin
    hold_q <= (sys_rst_i || !core_reset_o || vector_fetch_o) ? 16'h0000 : hold_q + 16'h0001;
    lock_q <= (sys_rst_i || !pll_lock_i) ? 16'h0000 : lock_q + 16'h0001;
  end
  default clocking @(posedge clk_sys_i); endclocking
  default disable iff (sys_rst_i);
  a_fetch_len: assert property (
    $rose(vector_fetch_o) |-> vector_fetch_o[*2] ##1 !vector_fetch_o)
    else $error("fetch length wrong");
  a_fetch_run: assert property ($fell(vector_fetch_o) |-> !core_reset_o)
    else $error("no run after fetch");
  a_sa_delay: assert property (
    $rose(vector_fetch_o) && !clk_ctrl_o.usb_enable |-> hold_q >= 16'h0200)
    else $error("stand-alone delay short");
  a_usb_delay: assert property (
    $rose(vector_fetch_o) && clk_ctrl_o.usb_enable |-> lock_q >= 16'h0100)
    else $error("usb delay short");
  a_lvd_pin: assert property (
    !vdd_above_falling_i [*4] |-> reset_pin_oe_o && !reset_pin_o)
    else $error("reset pin not low");
  a_usb_clk: assert property (
    clk_ctrl_o.usb_enable |-> usb_supply_switch_out_oe_o && !usb_supply_switch_out_o
      && clk_ctrl_o.pll_enable && clk_ctrl_o.core_max_mhz == 8'h08
      && !clk_ctrl_o.clk_from_xtal_div)
    else $error("usb mode outputs wrong");
  a_sa_clk: assert property (
    !clk_ctrl_o.usb_enable |-> !usb_supply_switch_out_oe_o && !clk_ctrl_o.pll_enable
      && clk_ctrl_o.core_max_mhz == 8'h06 && clk_ctrl_o.clk_from_xtal_div)
    else $error("stand-alone outputs wrong");
  a_mode_hold: assert property ($changed(clk_ctrl_o.usb_enable) |-> core_reset_o)
    else $error("mode changed outside reset");
  a_io_float: assert property (core_reset_o |-> io_float_o)
    else $error("ports not floating in reset");
  a_vsel_code: assert property (regulator_level_code_o == regulator_voltage_sel_o)
    else $error("level code mismatch");
endmodule
bind rdsm_core rdsm_core_sva rdsm_core_sva_i (.clk_sys_i, .sys_rst_i, .vdd_above_falling_i,
  .pll_lock_i, .reset_pin_o, .reset_pin_oe_o, .core_reset_o, .vector_fetch_o, .io_float_o,
  .usb_supply_switch_out_o, .usb_supply_switch_out_oe_o, .clk_ctrl_o,
  .regulator_voltage_sel_o, .regulator_level_code_o);

// File: rdsm_supply_model.sv
// Behavioural model of the supply comparators, the PLL and the supply switch.
// Assumes zones: 0 below the falling threshold, 1 between, 2 above the rising one.
`timescale 1ns/10ps
module rdsm_supply_model #(
  parameter int LOCK_DLY = 20
) (
  input wire logic clk_sys_i,
  input wire logic [1:0] vdd_zone_i,
  input wire logic [1:0] usb_zone_i,
  input wire logic pll_enable_i,
  input wire logic sw_pin_i,
  input wire logic sw_oe_i,
  output logic vdd_above_rising_o,
  output logic vdd_above_falling_o,
  output logic usb_above_rising_o,
  output logic usb_above_falling_o,
  output logic pll_lock_o,
  output logic sw_on_o
);
  int lock_cnt_q = 0;
  assign vdd_above_rising_o = vdd_zone_i == 2'h2;
  assign vdd_above_falling_o = vdd_zone_i != 2'h0;
  assign usb_above_rising_o = usb_zone_i == 2'h2;
  assign usb_above_falling_o = usb_zone_i != 2'h0;
  // The switch gate has a pull-up, so a released pin leaves the switch off.
  assign sw_on_o = sw_oe_i && !sw_pin_i;
  assign pll_lock_o = lock_cnt_q >= LOCK_DLY;
  always @(posedge clk_sys_i) begin
    lock_cnt_q <= !pll_enable_i ? 0 : (pll_lock_o ? lock_cnt_q : lock_cnt_q + 1);
  end
endmodule

// File: rdsm_tb.sv
// Self-checking testbench for the reset and supply manager.
// Assumes the package, the core, its checker and the supply model are compiled first.
`timescale 1ns/10ps
module testbench;
  import rdsm_pkg::*;
  logic clk_sys_i = 1'b0;
  logic sys_rst_i = 1'b1;
  logic ext_rst_n = 1'b1;
  logic wdog = 1'b0;
  logic [1:0] vdd_zone = 2'h2;
  logic [1:0] usb_zone = 2'h0;
  rdsm_axi_req_s req = '{bready: 1'b1, rready: 1'b1, default: '0};
  rdsm_axi_rsp_s rsp;
  rdsm_clk_ctrl_s cc;
  logic vr, vf, ur, uf, lock, rpin_oe, core_rst, fetch, sw, sw_oe, sw_on, reg_en, irq, det_off;
  logic [1:0] vsel;
  logic [1:0] lvl;
  int err_count = 0;
  int total_checks = 0;
  always #5 clk_sys_i = ~clk_sys_i;
  rdsm_core rdsm_core_i (.clk_sys_i, .sys_rst_i, .axi_req_i(req), .axi_rsp_o(rsp),
    .ext_reset_n_i(ext_rst_n), .watchdog_reset_i(wdog), .vdd_above_rising_i(vr),
    .vdd_above_falling_i(vf), .usb_above_rising_i(ur), .usb_above_falling_i(uf),
    .pll_lock_i(lock), .reset_pin_o(), .reset_pin_oe_o(rpin_oe), .core_reset_o(core_rst),
    .vector_fetch_o(fetch), .io_float_o(), .usb_supply_switch_out_o(sw),
    .usb_supply_switch_out_oe_o(sw_oe), .clk_ctrl_o(cc), .regulator_enable_o(reg_en),
    .regulator_voltage_sel_o(vsel), .regulator_level_code_o(lvl),
    .detector_power_down_o(det_off), .plug_irq_o(irq));
  rdsm_supply_model rdsm_supply_model_i (.clk_sys_i, .vdd_zone_i(vdd_zone),
    .usb_zone_i(usb_zone), .pll_enable_i(cc.pll_enable), .sw_pin_i(sw), .sw_oe_i(sw_oe),
    .vdd_above_rising_o(vr), .vdd_above_falling_o(vf), .usb_above_rising_o(ur),
    .usb_above_falling_o(uf), .pll_lock_o(lock), .sw_on_o(sw_on));
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      err_count++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic finish_test();
    $display("checks %0d, mismatches %0d", total_checks, err_count);
    if (err_count == 0 && total_checks > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask
  task automatic give_up();
    err_count++;
    finish_test();
  endtask
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    logic aw;
    logic w;
    aw = 1'b1;
    w = 1'b1;
    req.awaddr <= a;
    req.wdata <= d;
    req.wstrb <= 4'h1;
    req.awvalid <= 1'b1;
    req.wvalid <= 1'b1;
    for (int n = 0; n < 50; n++) begin
      @(posedge clk_sys_i);
      if (!aw && !w && rsp.bvalid) begin
        check({30'h0, rsp.bresp}, 32'h0);
        return;
      end
      if (aw && rsp.awready) begin
        aw = 1'b0;
        req.awvalid <= 1'b0;
      end
      if (w && rsp.wready) begin
        w = 1'b0;
        req.wvalid <= 1'b0;
      end
    end
    give_up();
  endtask
  task automatic rd_chk(input logic [11:0] a, input logic [31:0] e, input logic [1:0] er);
    logic ar;
    ar = 1'b1;
    req.araddr <= a;
    req.arvalid <= 1'b1;
    for (int n = 0; n < 50; n++) begin
      @(posedge clk_sys_i);
      if (!ar && rsp.rvalid) begin
        check(rsp.rdata, e);
        check({30'h0, rsp.rresp}, {30'h0, er});
        return;
      end
      if (rsp.arready) begin
        ar = 1'b0;
        req.arvalid <= 1'b0;
      end
    end
    give_up();
  endtask
  // Counts edges up to the first one that samples the signal away from the given level.
  task automatic span(ref logic s, input logic v, output int n);
    n = 0;
    while (s === v) begin
      @(posedge clk_sys_i);
      n++;
      if (n > 2000)
        give_up();
    end
  endtask
  task automatic wait_lvl(ref logic s, input logic v);
    int n;
    span(s, ~v, n);
  endtask
  task automatic regulator();
    for (int i = 0; i < 4; i++) begin
      wr(12'h000, 32'h0000_0001 | (i << 2));
      check({29'h0, reg_en, lvl}, 32'h0000_0004 | i);
      rd_chk(12'h000, 32'h0000_0001 | (i << 2), 2'h0);
    end
    wr(12'h000, 32'h0000_0002);
    check({31'h0, det_off}, 32'h1);
    rd_chk(12'h000, 32'h0000_00e2, 2'h0);
    wr(12'h000, 32'h0000_0000);
    check({31'h0, reg_en}, 32'h0);
  endtask
  task automatic sa_delay();
    int n;
    wdog <= 1'b1;
    repeat (2) @(posedge clk_sys_i);
    wdog <= 1'b0;
    span(fetch, 1'b0, n);
    check(n, 32'h0000_0202);
    check({cc.pll_enable, cc.usb_enable, sw_on, cc.core_max_mhz}, 32'h0000_0006);
    span(fetch, 1'b1, n);
    check(n, 32'h0000_0002);
    check({31'h0, core_rst}, 32'h0);
  endtask
  task automatic lvd_band();
    vdd_zone <= 2'h1;
    repeat (10) @(posedge clk_sys_i);
    check({31'h0, core_rst}, 32'h0);
    vdd_zone <= 2'h0;
    wait_lvl(rpin_oe, 1'b1);
    vdd_zone <= 2'h1;
    repeat (20) @(posedge clk_sys_i);
    check({30'h0, rpin_oe, core_rst}, 32'h0000_0003);
    vdd_zone <= 2'h2;
    wait_lvl(core_rst, 1'b0);
  endtask
  task automatic plug_irq();
    usb_zone <= 2'h2;
    repeat (10) @(posedge clk_sys_i);
    check({31'h0, irq}, 32'h0);
    rd_chk(12'h000, 32'h0000_00e0, 2'h0);
    usb_zone <= 2'h0;
    wr(12'h000, 32'h0000_0010);
    repeat (10) @(posedge clk_sys_i);
    usb_zone <= 2'h1;
    repeat (10) @(posedge clk_sys_i);
    check({31'h0, irq}, 32'h0);
    usb_zone <= 2'h2;
    wait_lvl(irq, 1'b1);
    wr(12'h000, 32'h0000_0030);
    check({31'h0, irq}, 32'h0);
  endtask
  task automatic usb_mode();
    int n;
    wr(12'h008, 32'h0000_0001);
    wait_lvl(lock, 1'b1);
    check({sw_on, core_rst, cc.core_max_mhz}, 32'h0000_0308);
    span(fetch, 1'b0, n);
    check({31'h0, n >= 256 && n <= 260}, 32'h1);
    span(fetch, 1'b1, n);
    check({31'h0, sw_on}, 32'h1);
    rd_chk(12'h004, 32'h0000_0015, 2'h0);
    wr(12'h000, 32'h0000_0010);
    usb_zone <= 2'h1;
    repeat (10) @(posedge clk_sys_i);
    rd_chk(12'h000, 32'h0000_0070, 2'h0);
    usb_zone <= 2'h0;
    repeat (10) @(posedge clk_sys_i);
    rd_chk(12'h000, 32'h0000_0010, 2'h0);
    check({31'h0, irq}, 32'h1);
    wr(12'h008, 32'h0000_0001);
    wait_lvl(core_rst, 1'b1);
    check({cc.pll_enable, cc.clk_from_xtal_div, sw_oe, sw_on}, 32'h0000_0004);
    wait_lvl(core_rst, 1'b0);
    check({cc.pll_enable, cc.clk_from_xtal_div, sw_oe, sw_on}, 32'h0000_0004);
  endtask
  initial begin
    repeat (4) @(posedge clk_sys_i);
    sys_rst_i <= 1'b0;
    rd_chk(12'h000, 32'h0000_0000, 2'h0);
    rd_chk(12'h00c, 32'h0000_0000, 2'h2);
    wait_lvl(core_rst, 1'b0);
    regulator();
    sa_delay();
    lvd_band();
    plug_irq();
    usb_mode();
    finish_test();
  end
endmodule
